// [logic/arf_filter.sv]
`timescale 1ns/1ps
module arf_filter
  import arf_pkg::*;
#(
  parameter int NODES = 63
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bus_reset_in,
  input wire logic link_enable_in,
  input wire logic ctx_enable_in,
  input wire logic [9:0] local_bus_field_in,
  input wire logic local_bus_load_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic pkt_valid_in,
  input wire arf_hdr_t pkt_hdr_in,
  output arf_dec_t dec_out,
  output logic dec_valid_out
);

  // Storage overview
  // Two 64-bit vectors and the local bus number hold the whole filter state.
  // Bits 62:0 are per-node enables, one per local node number.
  // Bit 63 is the wide control of each vector.
  // In the request vector it admits every node on every bus.
  // In the physical vector it admits nodes on foreign buses only.
  // Keeping both vectors 64 bits wide lets the source node index
  // them directly, with no subtraction or split per half.
  // Node 63 would land on bit 63, so the hit logic masks it out.
  // Accept state: request vector and physical vector, bit 63 = all/other-bus
  logic [63:0] req_vec_r;
  logic [63:0] req_vec_nxt;
  logic [63:0] phy_vec_r;
  logic [63:0] phy_vec_nxt;
  logic [9:0] local_bus_number_r; // Bus number used for source matching
  logic [31:0] reg_rdata_r;
  logic reg_ack_r;
  arf_dec_t dec_r;
  logic dec_valid_r;

  // Register interface notes
  // Writes and reads are single-cycle strobes, no wait states.
  // The acknowledge always follows one cycle after any strobe,
  // so the host never has to poll for completion.
  // Each pair has a set port and a clear port at adjacent words.
  // Both ports of a pair read back the same current state.
  // Unmapped or unaligned reads return zero rather than stale data.
  // Unmapped writes are ignored and still acknowledged.
  // Register address decode
  wire logic hit_rhs = reg_wr_in && (reg_addr_in == ARF_REQ_HI_SET);
  wire logic hit_rhc = reg_wr_in && (reg_addr_in == ARF_REQ_HI_CLR);
  wire logic hit_rls = reg_wr_in && (reg_addr_in == ARF_REQ_LO_SET);
  wire logic hit_rlc = reg_wr_in && (reg_addr_in == ARF_REQ_LO_CLR);
  wire logic hit_phs = reg_wr_in && (reg_addr_in == ARF_PHY_HI_SET);
  wire logic hit_phc = reg_wr_in && (reg_addr_in == ARF_PHY_HI_CLR);
  wire logic hit_pls = reg_wr_in && (reg_addr_in == ARF_PHY_LO_SET);
  wire logic hit_plc = reg_wr_in && (reg_addr_in == ARF_PHY_LO_CLR);

  // Set and clear masks
  // Only the strobed port contributes a mask; all others give zero.
  // A mask of zeros leaves the vector exactly as it was, which is
  // what lets software change one node without a read first.
  // Software cannot set and clear in one atomic write; it takes
  // two writes, and another request may be judged in between.
  // Write-one masks per vector; zero bits leave state alone
  wire logic [63:0] req_set = {hit_rhs ? reg_wdata_in : 32'h0, hit_rls ? reg_wdata_in : 32'h0};
  wire logic [63:0] req_clr = {hit_rhc ? reg_wdata_in : 32'h0, hit_rlc ? reg_wdata_in : 32'h0};
  wire logic [63:0] phy_set = {hit_phs ? reg_wdata_in : 32'h0, hit_pls ? reg_wdata_in : 32'h0};
  wire logic [63:0] phy_clr = {hit_phc ? reg_wdata_in : 32'h0, hit_plc ? reg_wdata_in : 32'h0};

  // Next-state hazard
  // A bus reset and a set write may meet in the same cycle.
  // The reset is a hardware event and must not be undone by a
  // write that software issued before it saw the reset, so the
  // reset branch is applied last and overrides the masks.
  // The accept-all bit alone is carried through the reset.
  // Next state: bus reset wins over software; accept-all survives it
  always_comb
  begin
    req_vec_nxt = (req_vec_r | req_set) & ~req_clr;
    phy_vec_nxt = (phy_vec_r | phy_set) & ~phy_clr;
    if (bus_reset_in)
    begin
      req_vec_nxt = {req_vec_nxt[ARF_ALL_BIT + 32], 63'h0};
      phy_vec_nxt = 64'h0;
    end
  end

  // Vector state
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      req_vec_r <= {ARF_REG_RESET, ARF_REG_RESET};
      phy_vec_r <= {ARF_REG_RESET, ARF_REG_RESET};
    end
    else
    begin
      req_vec_r <= req_vec_nxt;
      phy_vec_r <= phy_vec_nxt;
    end
  end

  // Local bus number
  // After a bus reset the bus number is unknown until software
  // loads it again; until then only the unset value matches.
  // A load in the same cycle as a bus reset is lost on purpose.
  // Local bus number, forced to unset on every bus reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      local_bus_number_r <= ARF_BUS_UNSET;
    else if (bus_reset_in)
      local_bus_number_r <= ARF_BUS_UNSET;
    else if (local_bus_load_in)
      local_bus_number_r <= local_bus_field_in;
  end

  // Read path
  // Address bit 2 selects set or clear; it is dropped for reads
  // so both ports return the same word.
  // Read data is zero whenever no read is strobed, which keeps
  // the shared host bus quiet between accesses.
  // Read mux: set and clear addresses of a pair return the same word
  wire logic [11:0] rd_pair = {reg_addr_in[11:3], 3'h0};
  wire logic addr_ok = (reg_addr_in[1:0] == 2'h0);
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0;
    if (addr_ok)
    begin
      case (rd_pair)
        ARF_REQ_HI_SET: rd_word = req_vec_r[63:32];
        ARF_REQ_LO_SET: rd_word = req_vec_r[31:0];
        ARF_PHY_HI_SET: rd_word = phy_vec_r[63:32];
        ARF_PHY_LO_SET: rd_word = phy_vec_r[31:0];
        default: rd_word = 32'h0; // Unmapped reads return zero
      endcase
    end
  end

  // Read data registered so every output comes from a flop
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_r <= 32'h0;
      reg_ack_r <= 1'b0;
    end
    else
    begin
      reg_rdata_r <= reg_rd_in ? rd_word : 32'h0;
      reg_ack_r <= reg_rd_in || reg_wr_in;
    end
  end

  // Source matching
  // The header is judged in the cycle it is presented; the
  // result is registered so the decision arrives one cycle later.
  // Local means either the unset bus number or the loaded one.
  // Foreign buses never hit a per-node bit.
  // Source id split into bus and node
  wire logic [9:0] src_bus = pkt_hdr_in.source_id[15:6];
  wire logic [5:0] src_node = pkt_hdr_in.source_id[5:0];
  wire logic bus_local = (src_bus == ARF_BUS_UNSET) || (src_bus == local_bus_number_r);
  // Node 63 has no per-node bit; the index then reads bit 63, so mask it
  wire logic node_real = (src_node != ARF_NODE_NONE);

  // Per-node hits
  wire logic req_node_hit = bus_local && node_real && req_vec_r[src_node];
  wire logic req_ok = req_vec_r[ARF_ALL_BIT + 32] || req_node_hit;
  wire logic phy_node_hit = bus_local && node_real && phy_vec_r[src_node];
  wire logic phy_other = !bus_local && phy_vec_r[ARF_ALL_BIT + 32];
  wire logic phy_ok = phy_node_hit || phy_other;

  // Classification notes
  // Responses pass unfiltered: they answer our own requests.
  // The bypass regions keep discovery working for any node,
  // even when software has closed every per-node bit.
  // The physical range limit is inclusive.
  // Packet classification
  wire logic [3:0] tc = pkt_hdr_in.tcode;
  wire logic is_resp = (tc == ARF_TC_RESP_WR) || (tc == ARF_TC_RESP_QRD) ||
                       (tc == ARF_TC_RESP_BRD) || (tc == ARF_TC_RESP_LOCK);
  wire logic [47:0] off = pkt_hdr_in.offset;
  wire logic in_rom = (off >= ARF_ROM_BASE) && (off <= ARF_ROM_END);
  wire logic rom_qrd = (tc == ARF_TC_QRD) && (off >= ARF_ROM_BASE) && (off <= ARF_ROMHDR_END);
  wire logic in_irm = (off >= ARF_IRM_BASE) && (off <= ARF_IRM_END);
  wire logic bypass = rom_qrd || in_irm || (link_enable_in && in_rom);
  wire logic in_phys = (off <= ARF_PHYS_TOP);
  // Lock or block with extended code never served physically
  wire logic phys_forbid = (tc == ARF_TC_LOCK) ||
    (((tc == ARF_TC_BWR) || (tc == ARF_TC_BRD)) && (pkt_hdr_in.ext_tcode != 16'h0));

  // Decision priority
  // 1. Responses and bypass regions always pass with an ack.
  // 2. A refused source is dropped silently, no ack at all.
  // 3. Allowed physical requests may go to the physical unit.
  // 4. Everything else goes to the receive context if enabled.
  // 5. Otherwise the request is dropped without an ack.
  // Routing decision
  arf_dec_t dec_nxt;
  always_comb
  begin
    dec_nxt.route = ARF_DROP;
    dec_nxt.send_ack = 1'b0;
    if (is_resp || bypass)
    begin
      dec_nxt.route = ARF_PASS;
      dec_nxt.send_ack = 1'b1;
    end
    else if (!req_ok)
    begin
      dec_nxt.route = ARF_DROP;
      dec_nxt.send_ack = 1'b0;
    end
    else if (in_phys && !phys_forbid && phy_ok)
    begin
      dec_nxt.route = ARF_TO_PHYS;
      dec_nxt.send_ack = 1'b1;
    end
    else if (ctx_enable_in)
    begin
      dec_nxt.route = ARF_TO_CTX;
      dec_nxt.send_ack = 1'b1;
    end
    else
    begin
      dec_nxt.route = ARF_DROP;
      dec_nxt.send_ack = 1'b0;
    end
  end

  // Output timing
  // The decision is recomputed every cycle; only the valid pulse
  // tells the consumer which cycle belongs to a real header.
  // Decision register, one cycle after the header
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      dec_r <= '{route: ARF_DROP, send_ack: 1'b0};
      dec_valid_r <= 1'b0;
    end
    else
    begin
      dec_r <= dec_nxt;
      dec_valid_r <= pkt_valid_in;
    end
  end

  assign reg_rdata_out = reg_rdata_r;
  assign reg_ack_out = reg_ack_r;
  assign dec_out = dec_r;
  assign dec_valid_out = dec_valid_r;
endmodule

// [logic/arf_pkg.sv]
package arf_pkg;
  // Register byte offsets (set / clear pairs)
  localparam logic [11:0] ARF_REQ_HI_SET = 12'h100;
  localparam logic [11:0] ARF_REQ_HI_CLR = 12'h104;
  localparam logic [11:0] ARF_REQ_LO_SET = 12'h108;
  localparam logic [11:0] ARF_REQ_LO_CLR = 12'h10C;
  localparam logic [11:0] ARF_PHY_HI_SET = 12'h110;
  localparam logic [11:0] ARF_PHY_HI_CLR = 12'h114;
  localparam logic [11:0] ARF_PHY_LO_SET = 12'h118;
  localparam logic [11:0] ARF_PHY_LO_CLR = 12'h11C;
  // Field positions and fixed values
  localparam int ARF_ALL_BIT = 31;
  localparam logic [31:0] ARF_REG_RESET = 32'h0000_0000;
  localparam logic [9:0] ARF_BUS_UNSET = 10'h3FF;
  localparam logic [5:0] ARF_NODE_NONE = 6'h3F;
  localparam logic [47:0] ARF_PHYS_TOP = 48'h0000_FFFF_FFFF;
  localparam logic [47:0] ARF_ROM_BASE = 48'hFFFF_F000_0400;
  localparam logic [47:0] ARF_ROM_END = 48'hFFFF_F000_07FF;
  localparam logic [47:0] ARF_IRM_BASE = 48'hFFFF_F000_021C;
  localparam logic [47:0] ARF_IRM_END = 48'hFFFF_F000_0228;
  localparam logic [47:0] ARF_ROMHDR_END = 48'hFFFF_F000_0417;
  // Transaction codes of interest
  localparam logic [3:0] ARF_TC_QRD = 4'h4;
  localparam logic [3:0] ARF_TC_BWR = 4'h1;
  localparam logic [3:0] ARF_TC_BRD = 4'h5;
  localparam logic [3:0] ARF_TC_LOCK = 4'h9;
  localparam logic [3:0] ARF_TC_RESP_WR = 4'h2;
  localparam logic [3:0] ARF_TC_RESP_QRD = 4'h6;
  localparam logic [3:0] ARF_TC_RESP_BRD = 4'h7;
  localparam logic [3:0] ARF_TC_RESP_LOCK = 4'hB;

  // Routing outcome
  typedef enum logic [1:0] {
    ARF_DROP = 2'b00,
    ARF_TO_CTX = 2'b01,
    ARF_TO_PHYS = 2'b10,
    ARF_PASS = 2'b11
  } arf_route_t;

  // Incoming packet header fields
  typedef struct packed {
    logic [15:0] source_id;
    logic [47:0] offset;
    logic [3:0] tcode;
    logic [15:0] ext_tcode;
  } arf_hdr_t;

  // Decision delivered downstream
  typedef struct packed {
    arf_route_t route;
    logic send_ack;
  } arf_dec_t;
endpackage

// [test/arf_node_model.sv]
`timescale 1ns/1ps
// Remote node: one request header per send pulse
module arf_node_model
  import arf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire arf_hdr_t hdr_in,
  output logic pkt_valid_out,
  output arf_hdr_t pkt_hdr_out
);
  // Header scrambles when idle so a stale value never looks valid
  always_ff @(posedge clk_in)
  begin
    pkt_valid_out <= send_in & ~rst_in;
    pkt_hdr_out <= rst_in ? '0 : (send_in ? hdr_in : ~pkt_hdr_out);
  end
endmodule

// [test/arf_filter_props.sv]
`timescale 1ns/1ps
// Port-level timing and routing checks
module arf_filter_props
  import arf_pkg::*;
#(
  parameter int NODES = 63
)
(
  input wire logic clk_in, rst_in, bus_reset_in, link_enable_in, ctx_enable_in,
  input wire logic [9:0] local_bus_field_in,
  input wire logic local_bus_load_in, reg_wr_in, reg_rd_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out,
  input wire logic reg_ack_out, pkt_valid_in,
  input wire arf_hdr_t pkt_hdr_in,
  input wire arf_dec_t dec_out,
  input wire logic dec_valid_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Header shorthands
  wire [47:0] off = pkt_hdr_in.offset;
  wire [3:0] tc = pkt_hdr_in.tcode;
  property p_ack; (reg_wr_in || reg_rd_in) |=> reg_ack_out; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_idle; !reg_rd_in |=> reg_rdata_out == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_dv; pkt_valid_in |=> dec_valid_out; endproperty
  a_dv: assert property (p_dv) else $error("no decision");
  property p_drop; dec_valid_out && dec_out.route == ARF_DROP |-> !dec_out.send_ack; endproperty
  a_drop: assert property (p_drop) else $error("ack on drop");
  property p_resp; pkt_valid_in && tc == ARF_TC_RESP_WR |=> dec_out.route == ARF_PASS; endproperty
  a_resp: assert property (p_resp) else $error("response filtered");
  // Lock in physical range never goes to the physical unit
  property p_lock; pkt_valid_in && tc == ARF_TC_LOCK && off <= ARF_PHYS_TOP
    |=> dec_out.route != ARF_TO_PHYS; endproperty
  a_lock: assert property (p_lock) else $error("lock served physically");
  property p_ctx; pkt_valid_in && !ctx_enable_in |=> dec_out.route != ARF_TO_CTX; endproperty
  a_ctx: assert property (p_ctx) else $error("disabled context used");
  // Read right after a bus reset sees cleared node bits
  property p_brst; bus_reset_in ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == ARF_REQ_LO_SET
    |=> reg_rdata_out == 32'h0; endproperty
  a_brst: assert property (p_brst) else $error("node bits survived");
endmodule
bind arf_filter arf_filter_props #(.NODES(NODES)) u_props (.clk_in, .rst_in, .bus_reset_in,
  .link_enable_in, .ctx_enable_in, .local_bus_field_in, .local_bus_load_in, .reg_wr_in,
  .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .pkt_valid_in,
  .pkt_hdr_in, .dec_out, .dec_valid_out);

// [test/arf_filter_tb.sv]
`timescale 1ns/1ps
// Register pairs, filtering, routing and bus reset at the ports
module arf_filter_tb
  import arf_pkg::*;
;
  localparam logic [47:0] far_off = 48'h0001_0000_0000;
  logic clk_in = 1'b0, rst_in = 1'b1, bus_reset_in = 1'b0, link_enable_in = 1'b1;
  logic ctx_enable_in = 1'b1, local_bus_load_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic send = 1'b0, pv, reg_ack_out, dec_valid_out;
  logic [9:0] local_bus_field_in = 10'h000;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  arf_hdr_t hdr = '0, ph;
  arf_dec_t dec_out;
  int num_errors = 0, total_checks = 0;
  // 10 MHz clock
  always #50 clk_in = ~clk_in;
  arf_node_model node (.clk_in, .rst_in, .send_in(send), .hdr_in(hdr),
    .pkt_valid_out(pv), .pkt_hdr_out(ph));
  arf_filter #(.NODES(63)) uut (.clk_in, .rst_in, .bus_reset_in, .link_enable_in,
    .ctx_enable_in, .local_bus_field_in, .local_bus_load_in, .reg_wr_in, .reg_rd_in,
    .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .pkt_valid_in(pv),
    .pkt_hdr_in(ph), .dec_out, .dec_valid_out);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One register cycle; a write must leave read data at zero
  task rop(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= w;
    reg_rd_in <= !w;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1;
    chk(32'(reg_ack_out), 32'h1);
    chk(reg_rdata_out, w ? 32'h0 : d);
  endtask
  // Header via node model; decision lands two edges later
  task pk(input logic [15:0] s, input logic [47:0] o, input logic [3:0] t,
    input logic [15:0] e, input arf_route_t r);
    @(posedge clk_in);
    send <= 1'b1;
    hdr <= '{s, o, t, e};
    @(posedge clk_in);
    send <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(32'(dec_valid_out), 32'h1);
    chk(32'(dec_out.route), 32'(r));
    chk(32'(dec_out.send_ack), 32'(r != ARF_DROP));
  endtask
  task t_regs;
    for (int i = 0; i < 8; i++)
      rop(1'b0, 12'h100 + 12'(4 * i), 32'h0);
    rop(1'b1, ARF_REQ_LO_SET, 32'h20);
    rop(1'b0, ARF_REQ_LO_CLR, 32'h20);
    rop(1'b1, ARF_REQ_LO_CLR, 32'h20);
    rop(1'b0, ARF_REQ_LO_SET, 32'h0);
    rop(1'b0, 12'h120, 32'h0);
    $display("regs done");
  endtask
  task t_bypass;
    pk(16'hFFC5, ARF_ROM_BASE, ARF_TC_QRD, 16'h0, ARF_PASS);
    pk(16'hFFC5, ARF_IRM_BASE, ARF_TC_BWR, 16'h0, ARF_PASS);
    pk(16'hFFC5, ARF_ROM_BASE + 48'h100, ARF_TC_BWR, 16'h0, ARF_PASS);
    @(posedge clk_in);
    link_enable_in <= 1'b0;
    pk(16'hFFC5, ARF_ROM_BASE + 48'h100, ARF_TC_BWR, 16'h0, ARF_DROP);
    @(posedge clk_in);
    link_enable_in <= 1'b1;
    pk(16'hFFC5, 48'h0, ARF_TC_RESP_WR, 16'h0, ARF_PASS);
    pk(16'hFFC5, far_off, ARF_TC_BWR, 16'h0, ARF_DROP);
    $display("bypass done");
  endtask
  task t_req;
    rop(1'b1, ARF_REQ_LO_SET, 32'h20);
    pk(16'hFFC5, far_off, ARF_TC_BWR, 16'h0, ARF_TO_CTX);
    @(posedge clk_in);
    local_bus_field_in <= 10'h005;
    local_bus_load_in <= 1'b1;
    @(posedge clk_in);
    local_bus_load_in <= 1'b0;
    pk(16'h0145, far_off, ARF_TC_BWR, 16'h0, ARF_TO_CTX);
    pk(16'h01C5, far_off, ARF_TC_BWR, 16'h0, ARF_DROP);
    pk(16'hFFFF, far_off, ARF_TC_BWR, 16'h0, ARF_DROP);
    rop(1'b1, ARF_REQ_HI_SET, 32'h100);
    pk(16'hFFE8, far_off, ARF_TC_BWR, 16'h0, ARF_TO_CTX);
    @(posedge clk_in);
    ctx_enable_in <= 1'b0;
    pk(16'hFFC5, far_off, ARF_TC_BWR, 16'h0, ARF_DROP);
    @(posedge clk_in);
    ctx_enable_in <= 1'b1;
    $display("request filter done");
  endtask
  task t_phys;
    pk(16'hFFC5, 48'h1000, ARF_TC_BWR, 16'h0, ARF_TO_CTX);
    rop(1'b1, ARF_PHY_LO_SET, 32'h20);
    pk(16'hFFC5, 48'h1000, ARF_TC_BWR, 16'h0, ARF_TO_PHYS);
    pk(16'hFFC5, 48'h1000, ARF_TC_LOCK, 16'h0, ARF_TO_CTX);
    pk(16'hFFC5, 48'h1000, ARF_TC_BWR, 16'h1, ARF_TO_CTX);
    rop(1'b1, ARF_REQ_HI_SET, 32'h8000_0000);
    pk(16'h01C9, 48'h1000, ARF_TC_BWR, 16'h0, ARF_TO_CTX);
    rop(1'b1, ARF_PHY_HI_SET, 32'h8000_0000);
    pk(16'h01C9, 48'h1000, ARF_TC_BWR, 16'h0, ARF_TO_PHYS);
    $display("physical filter done");
  endtask
  // Bus reset: node bits and physical bits clear, accept-all stays
  task t_brst;
    @(posedge clk_in);
    bus_reset_in <= 1'b1;
    @(posedge clk_in);
    bus_reset_in <= 1'b0;
    rop(1'b0, ARF_REQ_LO_SET, 32'h0);
    rop(1'b0, ARF_REQ_HI_CLR, 32'h8000_0000);
    rop(1'b0, ARF_PHY_HI_SET, 32'h0);
    rop(1'b0, ARF_PHY_LO_SET, 32'h0);
    rop(1'b1, ARF_REQ_HI_CLR, 32'h8000_0000);
    rop(1'b1, ARF_REQ_LO_SET, 32'h20);
    pk(16'h0145, far_off, ARF_TC_BWR, 16'h0, ARF_DROP);
    $display("bus reset done");
  endtask
  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_bypass;
    t_req;
    t_phys;
    t_brst;
    results;
  end
  // Hang guard at 1000 cycles, far past the roughly 120 cycles needed
  initial
  begin
    #100000;
    num_errors++;
    results;
  end
endmodule
